// File: logic/qdl_loader.sv
// Purpose: serial command loader for a quad 8-bit DAC
// Assumes: all pins except reset asynchronous to core_clk; serial clock far slower than core_clk
// Notes: pin levels pass two flops, so pin actions lag by about three cycles
`timescale 1ns/1ns
module qdl_loader
    import qdl_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic load_all_pin_n,
    input wire logic async_zero_pin_n,
    output logic serial_out,
    output logic [CHANNELS-1:0][DATA_BITS-1:0] dac_code,
    output logic [CHANNELS-1:0][DATA_BITS-1:0] input_code,
    output logic out_phase_falling,
    output logic [CNT_BITS-1:0] bits_received
);
    qdl_state_type state;
    qdl_state_type next_state;

    logic cs_low;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic [1:0] sel;
    logic [1:0] ctl;
    logic [DATA_BITS-1:0] data;

    assign cs_low = ~state.cs_sync[1];
    assign sclk_rise = state.sclk_sync[1] & ~state.sclk_prev;
    assign sclk_fall = ~state.sclk_sync[1] & state.sclk_prev;
    assign cs_rise = state.cs_sync[1] & ~state.cs_prev;
    assign sel = state.shift[SEL_HI_POS:SEL_LO_POS];
    assign ctl = state.shift[CTL_HI_POS:CTL_LO_POS];
    assign data = state.shift[DATA_BITS-1:0];

    always_comb begin
        next_state = state;
        next_state.cs_sync = {state.cs_sync[0], chip_select_n};
        next_state.sclk_sync = {state.sclk_sync[0], serial_clk};
        next_state.din_sync = {state.din_sync[0], serial_in};
        next_state.load_sync = {state.load_sync[0], load_all_pin_n};
        next_state.zero_sync = {state.zero_sync[0], async_zero_pin_n};
        next_state.sclk_prev = state.sclk_sync[1];
        next_state.cs_prev = state.cs_sync[1];
        unique case (state.mode)
            QDL_IDLE: begin
                if (cs_low) begin
                    next_state.mode = QDL_SHIFT;
                    next_state.bit_cnt = '0;
                end
            end
            QDL_SHIFT: begin
                if (!cs_low) begin
                    next_state.mode = QDL_IDLE;
                end
            end
        endcase
        // Frame start is seen one cycle late; an edge in that cycle still shifts
        if (cs_low && sclk_rise) begin
            next_state.shift = {state.shift[WORD_BITS-2:0], state.din_sync[1]};
            next_state.msb_hold = state.shift[WORD_BITS-1];
            if (state.mode == QDL_SHIFT && state.bit_cnt != CNT_FULL) begin
                next_state.bit_cnt = state.bit_cnt + 4'h1;
            end else if (state.mode == QDL_IDLE) begin
                next_state.bit_cnt = 4'h1;
            end
            if (!state.phase_falling) begin
                next_state.sout = state.shift[WORD_BITS-1];
            end
        end
        // Extra half stage gives the falling phase its half-period lag
        if (cs_low && sclk_fall && state.phase_falling) begin
            next_state.sout = state.msb_hold;
        end
        if (cs_rise) begin
            unique case (ctl)
                CTL_LOAD_INPUT: begin
                    next_state.in_reg[sel] = data;
                end
                CTL_LOAD_BOTH: begin
                    next_state.in_reg[sel] = data;
                    next_state.dac_reg[sel] = data;
                end
                CTL_SHIFT_ALL: begin
                    // Select low bit set is the pass-through word
                    if (!sel[0]) begin
                        for (int i = 0; i < CHANNELS; i++) begin
                            next_state.dac_reg[i] = data;
                        end
                    end
                end
                CTL_FROM_INPUT: begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        next_state.dac_reg[i] = state.in_reg[i];
                    end
                    if (sel == SEL_PHASE_FALL) begin
                        next_state.phase_falling = 1'b1;
                    end else if (sel == SEL_PHASE_RISE) begin
                        next_state.phase_falling = 1'b0;
                    end
                end
            endcase
        end
        if (!state.load_sync[1]) begin
            next_state.dac_reg = next_state.in_reg;
        end
        // Clear is applied last so it beats any command in flight
        if (!state.zero_sync[1]) begin
            for (int i = 0; i < CHANNELS; i++) begin
                next_state.in_reg[i] = CODE_RESET;
                next_state.dac_reg[i] = CODE_RESET;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state.cs_sync <= 2'h3;
            state.sclk_sync <= 2'h0;
            state.din_sync <= 2'h0;
            state.load_sync <= 2'h3;
            state.zero_sync <= 2'h3;
            state.sclk_prev <= 1'b0;
            state.cs_prev <= 1'b1;
            state.mode <= QDL_IDLE;
            state.shift <= SHIFT_RESET;
            state.msb_hold <= 1'b0;
            state.sout <= 1'b0;
            state.phase_falling <= PHASE_RESET;
            state.bit_cnt <= '0;
            state.in_reg <= '0;
            state.dac_reg <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Codes are straight binary; output level is code/256 of reference
    assign dac_code = state.dac_reg;
    assign input_code = state.in_reg;
    assign serial_out = state.sout;
    assign out_phase_falling = state.phase_falling;
    assign bits_received = state.bit_cnt;

    default clocking qdl_cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence cmd_exec_s(logic [1:0] c);
        cs_rise && ctl == c && state.zero_sync[1];
    endsequence

    sequence rise_edge_s;
        cs_low && sclk_rise;
    endsequence

    property shift_in_p;
        rise_edge_s |=> state.shift == {$past(state.shift[WORD_BITS-2:0]), $past(state.din_sync[1])};
    endproperty

    shift_in_a: assert property (shift_in_p)
        else $error("shift register did not take the serial bit");

    idle_hold_a: assert property (!cs_low && $past(!cs_low) |=> $stable(state.shift) && $stable(state.sout))
        else $error("shift or output moved while deselected");

    load_input_a: assert property (cmd_exec_s(CTL_LOAD_INPUT) ##0 state.load_sync[1]
        |=> state.in_reg[$past(sel)] == $past(data) && $stable(state.dac_reg))
        else $error("input load command wrong");

    load_both_a: assert property (cmd_exec_s(CTL_LOAD_BOTH)
        |=> state.dac_reg[$past(sel)] == $past(data) && state.in_reg[$past(sel)] == $past(data))
        else $error("input and DAC load command wrong");

    fall_phase_a: assert property (cmd_exec_s(CTL_FROM_INPUT) ##0 sel == SEL_PHASE_FALL
        |=> state.phase_falling && state.dac_reg == $past(state.in_reg))
        else $error("falling phase command wrong");

    phase_keep_a: assert property (!(cs_rise && ctl == CTL_FROM_INPUT && sel[1])
        |=> $stable(state.phase_falling))
        else $error("phase latch changed without a phase command");

    transparent_a: assert property (!state.load_sync[1] && state.zero_sync[1]
        |=> state.dac_reg == state.in_reg)
        else $error("DAC registers not transparent");

    clear_zero_a: assert property (!state.zero_sync[1]
        |=> state.in_reg == '0 && state.dac_reg == '0)
        else $error("clear did not zero registers");

    pass_word_a: assert property (cmd_exec_s(CTL_SHIFT_ALL) ##0 sel[0] && state.load_sync[1]
        |=> $stable(state.in_reg) && $stable(state.dac_reg))
        else $error("pass-through word changed a register");

    rise_out_a: assert property (rise_edge_s ##0 !state.phase_falling
        |=> state.sout == $past(state.shift[WORD_BITS-1]))
        else $error("rising phase output wrong");

    fall_out_a: assert property (cs_low && sclk_fall && state.phase_falling
        |=> state.sout == $past(state.msb_hold))
        else $error("falling phase output wrong");

    reset_state_a: assert property ($past(reset) |-> !state.phase_falling && state.bit_cnt == '0
        && state.dac_reg == '0)
        else $error("reset defaults wrong");

    // Broadcast write must reach every channel, not just the selected one
    shift_all_a: assert property (cmd_exec_s(CTL_SHIFT_ALL) ##0 !sel[0] && state.load_sync[1]
        |=> state.dac_reg == {CHANNELS{$past(data)}})
        else $error("load-all-from-shift command wrong");

    soft_load_a: assert property (cmd_exec_s(CTL_FROM_INPUT)
        |=> state.dac_reg == $past(state.in_reg))
        else $error("software load-all command wrong");

    rise_phase_a: assert property (cmd_exec_s(CTL_FROM_INPUT) ##0 sel == SEL_PHASE_RISE
        |=> !state.phase_falling)
        else $error("rising phase command wrong");

    count_cap_a: assert property (state.bit_cnt <= CNT_FULL)
        else $error("bit counter passed a full word");

    idle_count_a: assert property (!cs_low && $past(!cs_low) |=> $stable(state.bit_cnt))
        else $error("bit counter moved while deselected");
endmodule

// File: logic/qdl_pkg.sv
// Purpose: constants for the quad DAC serial loader
// Assumes: 12-bit command words; a longer chip select frame executes only its last 12 bits
// Notes: select/control code sits in the top four word bits
package qdl_pkg;
    localparam int WORD_BITS = 12;
    localparam int DATA_BITS = 8;
    localparam int CHANNELS = 4;
    localparam int CNT_BITS = 4;
    localparam int SEL_HI_POS = 11;
    localparam int SEL_LO_POS = 10;
    localparam int CTL_HI_POS = 9;
    localparam int CTL_LO_POS = 8;
    localparam logic [1:0] CTL_LOAD_INPUT = 2'h1;
    localparam logic [1:0] CTL_LOAD_BOTH = 2'h3;
    localparam logic [1:0] CTL_SHIFT_ALL = 2'h0;
    localparam logic [1:0] CTL_FROM_INPUT = 2'h2;
    localparam logic [1:0] SEL_PHASE_RISE = 2'h3;
    localparam logic [1:0] SEL_PHASE_FALL = 2'h2;
    localparam logic [CNT_BITS-1:0] CNT_FULL = 4'hC;
    localparam logic [WORD_BITS-1:0] SHIFT_RESET = 12'h000;
    localparam logic [DATA_BITS-1:0] CODE_RESET = 8'h00;
    localparam logic PHASE_RESET = 1'b0;
    localparam int LAG_RISE_PERIODS = 12;

    typedef enum logic [1:0] {
        QDL_IDLE = 2'b01,
        QDL_SHIFT = 2'b10
    } qdl_mode_type;

    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sclk_sync;
        logic [1:0] din_sync;
        logic [1:0] load_sync;
        logic [1:0] zero_sync;
        logic sclk_prev;
        logic cs_prev;
        qdl_mode_type mode;
        logic [WORD_BITS-1:0] shift;
        logic msb_hold;
        logic sout;
        logic phase_falling;
        logic [CNT_BITS-1:0] bit_cnt;
        logic [CHANNELS-1:0][DATA_BITS-1:0] in_reg;
        logic [CHANNELS-1:0][DATA_BITS-1:0] dac_reg;
    } qdl_state_type;
endpackage

// File: bench/qdl_host.sv
// Purpose: host serial master model driving the loader pins
// Assumes: clock idles low, data sampled on rising serial clock
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ns
module qdl_host (
    input wire logic core_clk,
    input wire logic serial_out,
    output logic chip_select_n,
    output logic serial_clk,
    output logic serial_in
);
    logic [23:0] cap;
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b0;
        cap = 24'h000000;
    end
    // Sends n bits MSB first; cap holds serial_out seen just before each fall
    task automatic send(input logic [23:0] w, input int n, input logic cs_hi);
        @(posedge core_clk);
        chip_select_n <= cs_hi;
        repeat (8) @(posedge core_clk);
        for (int k = n - 1; k >= 0; k--) begin
            serial_in <= w[k];
            repeat (8) @(posedge core_clk);
            serial_clk <= 1'b1;
            repeat (7) @(posedge core_clk);
            cap <= {cap[22:0], serial_out};
            @(posedge core_clk);
            serial_clk <= 1'b0;
        end
        repeat (8) @(posedge core_clk);
        chip_select_n <= 1'b1;
        serial_in <= ~w[0];
    endtask
endmodule

// File: bench/tb.sv
// Purpose: self-checking bench for the quad DAC serial loader
// Assumes: core clock 4 ns, serial clock period 64 ns
// Notes: pin actions lag a few core cycles, so checks wait 8 cycles
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb
    import qdl_pkg::*;
;
    logic core_clk, reset, load_n, zero_n, cs_n, sclk, sdi, sdo, phase;
    logic [CHANNELS-1:0][DATA_BITS-1:0] dac, inp, e_in, e_dac;
    logic [CNT_BITS-1:0] cnt;
    int n_fail = 0;
    int cmp_count = 0;
    qdl_host host_u(.core_clk(core_clk), .serial_out(sdo), .chip_select_n(cs_n), .serial_clk(sclk),
        .serial_in(sdi));
    qdl_loader dut_u(.core_clk(core_clk), .reset(reset), .chip_select_n(cs_n), .serial_clk(sclk),
        .serial_in(sdi), .load_all_pin_n(load_n), .async_zero_pin_n(zero_n), .serial_out(sdo),
        .dac_code(dac), .input_code(inp), .out_phase_falling(phase), .bits_received(cnt));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Read at the falling edge so no clocked update races the check
    task automatic settle;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic regs;
        `CHK("input_code", e_in, inp)
        `CHK("dac_code", e_dac, dac)
    endtask
    task automatic cmd(input logic [11:0] w);
        host_u.send({12'h000, w}, 12, 1'b0);
        settle();
        `CHK("bits", 4'hC, cnt)
    endtask
    task automatic t_input;
        for (int ch = 0; ch < 4; ch++) begin
            cmd({ch[1:0], 2'h1, 8'(8'h21 * ch + 8'h10)});
            e_in[ch] = 8'(8'h21 * ch + 8'h10);
            regs();
        end
        cmd(12'hBC3);
        e_in[2] = 8'hC3;
        e_dac[2] = 8'hC3;
        regs();
        cmd(12'h8A5);
        e_dac = {4{8'hA5}};
        regs();
    endtask
    // Last word of the frame is a pass-through; the first must reappear
    task automatic lag(input logic fall);
        host_u.send(24'hB2D4FF, 24, 1'b0);
        settle();
        regs();
        if (fall) begin
            `CHK("lag_fall", 11'h596, host_u.cap[10:0])
        end else begin
            `CHK("lag_rise", 12'hB2D, host_u.cap[11:0])
        end
    endtask
    task automatic t_phase;
        cmd(12'hA00);
        e_dac = e_in;
        `CHK("phase", 1'b1, phase)
        regs();
        cmd(12'h15A);
        e_in[0] = 8'h5A;
        cmd(12'h200);
        e_dac = e_in;
        `CHK("phase", 1'b1, phase)
        regs();
        lag(1'b1);
        cmd(12'hE00);
        `CHK("phase", 1'b0, phase)
        lag(1'b0);
    endtask
    task automatic t_load;
        cmd(12'hD3C);
        e_in[3] = 8'h3C;
        regs();
        @(posedge core_clk);
        load_n <= 1'b0;
        settle();
        e_dac = e_in;
        regs();
        cmd(12'h577);
        e_in[1] = 8'h77;
        e_dac = e_in;
        regs();
        @(posedge core_clk);
        load_n <= 1'b1;
    endtask
    // Serial clock toggled with the device deselected must do nothing
    task automatic t_idle;
        logic s;
        logic [CNT_BITS-1:0] c;
        s = sdo;
        c = cnt;
        host_u.send(24'h000A5A, 12, 1'b1);
        settle();
        `CHK("serial_out", s, sdo)
        `CHK("bits", c, cnt)
        regs();
    endtask
    task automatic t_clear;
        @(posedge core_clk);
        zero_n <= 1'b0;
        settle();
        e_in = {4{8'h00}};
        e_dac = {4{8'h00}};
        regs();
        cmd(12'h3EE);
        regs();
        @(posedge core_clk);
        zero_n <= 1'b1;
        settle();
        regs();
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        reset = 1'b1;
        load_n = 1'b1;
        zero_n = 1'b1;
        e_in = {4{8'h00}};
        e_dac = {4{8'h00}};
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        settle();
        `CHK("phase", 1'b0, phase)
        `CHK("bits", 4'h0, cnt)
        regs();
        t_input();
        t_phase();
        t_load();
        t_idle();
        t_clear();
        final_report();
    end
endmodule
